// ---- core/dbig_pkg.sv ----
// dbig_pkg: constants, register map and state types of the dual bus
// interrupt generator.
// assumes a single 100 MHz clock and a synchronous active high reset.

package dbig_pkg;

  // ----------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W  = 8;
  localparam int unsigned DATA_W  = 32;
  localparam int unsigned COND_W  = 6;
  localparam int unsigned LVL_W   = 3;
  localparam int unsigned LINE_W  = 7;
  localparam int unsigned CNT_W   = 16;

  // ----------------------------------------------------------------
  // condition bit positions
  // ----------------------------------------------------------------
  localparam int unsigned DATA_AVAILABLE_EVENT      = 0;
  localparam int unsigned BLOCK_AVAILABLE_EVENT     = 1;
  localparam int unsigned ARMED_WAITING_EVENT       = 2;
  localparam int unsigned ACQUISITION_STOPPED_EVENT = 3;
  localparam int unsigned INPUT_OVER_RANGE_EVENT    = 4;
  localparam int unsigned CONVERTER_FAULT_EVENT     = 5;

  // ----------------------------------------------------------------
  // register offsets; bit 4 of a generator offset is generator_select
  // ----------------------------------------------------------------
  localparam logic [7:0] GEN_CFG_OFS   = 8'h00;
  localparam logic [7:0] GEN_MASK_OFS  = 8'h04;
  localparam logic [7:0] GEN_LVL_OFS   = 8'h08;
  localparam logic [7:0] GEN_STRIDE    = 8'h10;
  localparam logic [7:0] BLK_SIZE_OFS  = 8'h20;
  localparam logic [7:0] COND_OFS      = 8'h24;
  localparam logic [7:0] IRQ_STAT_OFS  = 8'h28;
  localparam logic [7:0] IRQ_MASK_OFS  = 8'h2c;
  localparam logic [7:0] LINES_OFS     = 8'h30;
  localparam int unsigned GEN_SEL_BIT  = 4;

  // ----------------------------------------------------------------
  // field positions and legal bits
  // ----------------------------------------------------------------
  localparam int unsigned CFG_MASK_LSB = 0;
  localparam int unsigned CFG_LVL_LSB  = 8;
  localparam logic [31:0] MASK_LEGAL   = 32'h0000_003f;
  localparam logic [31:0] LVL_LEGAL    = 32'h0000_0007;
  localparam logic [31:0] CFG_LEGAL    = 32'h0000_073f;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [5:0]  MASK_RST     = 6'h00;
  localparam logic [2:0]  LVL_RST      = 3'h0;
  localparam logic [15:0] BLK_SIZE_RST = 16'h0400;

  // level setting to one-hot bus line, bit 0 is line 1
  function automatic logic [6:0] lvl_to_line(input logic [2:0] lvl);
    logic [6:0] line;
    line = 7'h00;
    if (lvl != 3'h0) begin
      line[lvl - 3'h1] = 1'b1;
    end
    return line;
  endfunction : lvl_to_line

  typedef struct packed {
    logic [1:0][5:0]  mask_q;
    logic [1:0][2:0]  lvl_q;
    logic [15:0]      blk_size_q;
    logic [5:0]       cond_q;
    logic [5:0]       cond_prev_q;
    logic [5:0]       stat_q;
    logic [5:0]       imask_q;
    logic [31:0]      rdata_q;
    logic [6:0]       line_oe_q;
    logic             irq_q;
  } dbig_state_t;

endpackage : dbig_pkg

// ---- core/dbig_sync.sv ----
// dbig_sync: two flip-flop synchroniser for asynchronous levels.
// assumes inputs are quasi-static levels; no pulse shorter than one
// clock period is guaranteed to pass.
`timescale 1ns/1ps
`default_nettype none

module dbig_sync #(
  parameter int unsigned W = 1
) (
  // clock and reset
  input  wire logic         ref_clk,
  input  wire logic         rst,
  // levels
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  typedef struct packed {
    logic [W-1:0] meta_q;
    logic [W-1:0] sync_q;
  } dbig_sync_t;

  dbig_sync_t st_q;
  dbig_sync_t st_d;

  // meta_q feeds only sync_q
  always_comb begin
    st_d        = st_q;
    st_d.meta_q = async_in;
    st_d.sync_q = st_q.meta_q;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign sync_out = st_q.sync_q;

endmodule : dbig_sync

`default_nettype wire

// ---- core/dbig_gen.sv ----
// dbig_gen: one interrupt generator, maps its mask, level and the
// current conditions onto one of the seven bus request lines.
// assumes registered level, mask and conditions from the caller.
`timescale 1ns/1ps
`default_nettype none

module dbig_gen
  import dbig_pkg::*;
(
  // setting
  input  wire logic [dbig_pkg::LVL_W-1:0]  lvl,
  input  wire logic [dbig_pkg::COND_W-1:0] mask,
  // conditions
  input  wire logic [dbig_pkg::COND_W-1:0] cond,
  // request lines, bit 0 is line 1
  output logic      [dbig_pkg::LINE_W-1:0] line_req
);

  logic hit;

  always_comb begin
    hit = |(mask & cond);
    line_req = hit ? lvl_to_line(lvl) : 7'h00;
  end

endmodule : dbig_gen

`default_nettype wire

// ---- core/dbig_top.sv ----
// dbig_top: two interrupt generators with register port, condition
// capture, sticky event status and open-drain bus request lines.
// assumes buffer count, armed and stopped come from logic on ref_clk;
// over range, fault and bus line levels arrive asynchronously.
`timescale 1ns/1ps
`default_nettype none

module dbig_top
  import dbig_pkg::*;
(
  // clock and reset
  input  wire logic                        ref_clk,
  input  wire logic                        rst,
  // register port
  input  wire logic [dbig_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [dbig_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  output logic      [dbig_pkg::DATA_W-1:0] reg_rdata,
  // measurement status, same clock
  input  wire logic [dbig_pkg::CNT_W-1:0]  buf_word_count,
  input  wire logic                        meas_armed,
  input  wire logic                        meas_stopped,
  // measurement status, asynchronous
  input  wire logic                        over_range_in,
  input  wire logic                        conv_fault_in,
  // bus request lines, open drain, low when driven
  input  wire logic [dbig_pkg::LINE_W-1:0] bus_irq_in,
  output logic      [dbig_pkg::LINE_W-1:0] bus_irq_out,
  output logic      [dbig_pkg::LINE_W-1:0] bus_irq_oe,
  // local interrupt
  output logic                             irq
);

  dbig_state_t st_q;
  dbig_state_t st_d;

  logic [1:0]        async_sync;
  logic [6:0]        lines_sync;
  logic [1:0][6:0]   gen_req;
  logic [6:0]        out_q;

  // ----------------------------------------------------------------
  // synchronisers
  // ----------------------------------------------------------------
  // sync over range and fault inputs
  dbig_sync #(.W(2)) u_sync_stat (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .async_in ({conv_fault_in, over_range_in}),
    .sync_out (async_sync)
  );

  dbig_sync #(.W(LINE_W)) u_sync_lines (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .async_in (bus_irq_in),
    .sync_out (lines_sync)
  );

  // ----------------------------------------------------------------
  // generators
  // ----------------------------------------------------------------
  // two independent generators
  for (genvar g = 0; g < 2; g++) begin : g_gen
    dbig_gen u_gen (
      .lvl      (st_q.lvl_q[g]),
      .mask     (st_q.mask_q[g]),
      .cond     (st_q.cond_q),
      .line_req (gen_req[g])
    );
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic        gen_hit;
  logic        gen_sel;
  logic [7:0]  gen_ofs;
  logic [5:0]  cond_now;
  logic [5:0]  w1c;
  logic [31:0] rval;

  always_comb begin
    st_d    = st_q;
    gen_sel = reg_addr[GEN_SEL_BIT];
    gen_ofs = reg_addr & ~GEN_STRIDE;
    gen_hit = reg_addr < (GEN_STRIDE << 1);
    w1c     = 6'h00;
    rval    = 32'h0000_0000;

    cond_now[DATA_AVAILABLE_EVENT]      = buf_word_count != 16'h0000;
    cond_now[BLOCK_AVAILABLE_EVENT]     = (st_q.blk_size_q != 16'h0000) &&
                                          (buf_word_count >= st_q.blk_size_q);
    cond_now[ARMED_WAITING_EVENT]       = meas_armed;
    cond_now[ACQUISITION_STOPPED_EVENT] = meas_stopped;
    cond_now[INPUT_OVER_RANGE_EVENT]    = async_sync[0];
    cond_now[CONVERTER_FAULT_EVENT]     = async_sync[1];
    st_d.cond_q      = cond_now;
    st_d.cond_prev_q = st_q.cond_q;

    if (reg_wr) begin
      if (gen_hit) begin
        unique case (gen_ofs)
          // mask and level together; refuse out of range
          GEN_CFG_OFS: begin
            if ((reg_wdata & ~CFG_LEGAL) == 32'h0000_0000) begin
              st_d.mask_q[gen_sel] = reg_wdata[CFG_MASK_LSB +: COND_W];
              st_d.lvl_q[gen_sel]  = reg_wdata[CFG_LVL_LSB +: LVL_W];
            end
          end
          GEN_MASK_OFS: begin
            if ((reg_wdata & ~MASK_LEGAL) == 32'h0000_0000) begin
              st_d.mask_q[gen_sel] = reg_wdata[5:0];
            end
          end
          GEN_LVL_OFS: begin
            if ((reg_wdata & ~LVL_LEGAL) == 32'h0000_0000) begin
              st_d.lvl_q[gen_sel] = reg_wdata[2:0];
            end
          end
          default: begin
          end
        endcase
      end else begin
        unique case (reg_addr)
          BLK_SIZE_OFS: st_d.blk_size_q = reg_wdata[15:0];
          IRQ_STAT_OFS: w1c = reg_wdata[5:0];
          IRQ_MASK_OFS: st_d.imask_q = reg_wdata[5:0];
          default: begin
          end
        endcase
      end
    end

    // rising condition sets a sticky bit; set wins over clear
    st_d.stat_q = (st_q.stat_q & ~w1c) | (st_q.cond_q & ~st_q.cond_prev_q);
    st_d.irq_q  = |(st_q.stat_q & st_q.imask_q);

    // registered line drive, both generators merged
    st_d.line_oe_q = gen_req[0] | gen_req[1];

    if (reg_rd) begin
      if (gen_hit) begin
        unique case (gen_ofs)
          GEN_CFG_OFS: begin
            rval[CFG_MASK_LSB +: COND_W] = st_q.mask_q[gen_sel];
            rval[CFG_LVL_LSB +: LVL_W]   = st_q.lvl_q[gen_sel];
          end
          GEN_MASK_OFS: rval[5:0] = st_q.mask_q[gen_sel];
          GEN_LVL_OFS:  rval[2:0] = st_q.lvl_q[gen_sel];
          default: begin
          end
        endcase
      end else begin
        unique case (reg_addr)
          BLK_SIZE_OFS: rval[15:0] = st_q.blk_size_q;
          COND_OFS:     rval[5:0]  = st_q.cond_q;
          IRQ_STAT_OFS: rval[5:0]  = st_q.stat_q;
          IRQ_MASK_OFS: rval[5:0]  = st_q.imask_q;
          LINES_OFS:    rval[6:0]  = lines_sync;
          default: begin
          end
        endcase
      end
    end
    // read data stand only in the cycle after the strobe
    st_d.rdata_q = rval;
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      st_q            <= '0;
      st_q.mask_q     <= {MASK_RST, MASK_RST};
      st_q.lvl_q      <= {LVL_RST, LVL_RST};
      st_q.blk_size_q <= BLK_SIZE_RST;
      out_q           <= 7'h00;
    end else begin
      st_q  <= st_d;
      out_q <= 7'h00;
    end
  end

  assign reg_rdata   = st_q.rdata_q;
  assign bus_irq_oe  = st_q.line_oe_q;
  assign bus_irq_out = out_q;
  assign irq         = st_q.irq_q;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  logic [1:0] any_hit;
  assign any_hit[0] = |(st_q.mask_q[0] & st_q.cond_q);
  assign any_hit[1] = |(st_q.mask_q[1] & st_q.cond_q);

  sequence s_cfg0_wr;
    reg_wr && reg_addr == GEN_CFG_OFS && (reg_wdata & ~CFG_LEGAL) == 32'h0;
  endsequence

  sequence s_mask0_rd;
    reg_rd && reg_addr == GEN_MASK_OFS;
  endsequence

  property p_all_off;
    @(posedge ref_clk) disable iff (rst)
      st_q.lvl_q[0] == 3'h0 && st_q.lvl_q[1] == 3'h0 |=> bus_irq_oe == 7'h00;
  endproperty
  a_all_off: assert property (p_all_off) else $error("line driven at level zero");

  property p_req0;
    @(posedge ref_clk) disable iff (rst)
      st_q.lvl_q[0] != 3'h0 && any_hit[0] |=> bus_irq_oe[$past(st_q.lvl_q[0]) - 3'h1];
  endproperty
  a_req0: assert property (p_req0) else $error("generator 0 request missing");

  property p_req1_only;
    @(posedge ref_clk) disable iff (rst)
      st_q.lvl_q[0] == 3'h0 && st_q.lvl_q[1] != 3'h0 && any_hit[1]
      |=> bus_irq_oe == lvl_to_line($past(st_q.lvl_q[1]));
  endproperty
  a_req1_only: assert property (p_req1_only) else $error("generator 1 wrong line");

  property p_top_line;
    @(posedge ref_clk) disable iff (rst)
      st_q.lvl_q[0] == 3'h7 && any_hit[0] |=> bus_irq_oe[6];
  endproperty
  a_top_line: assert property (p_top_line) else $error("level seven not top line");

  property p_after_reset;
    @(posedge ref_clk) disable iff (rst)
      $fell(rst) |-> st_q.lvl_q == 6'h00 && st_q.mask_q == 12'h000 ##1 bus_irq_oe == 7'h00;
  endproperty
  a_after_reset: assert property (p_after_reset) else $error("not clear after reset");

  property p_cfg_readback;
    @(posedge ref_clk) disable iff (rst)
      s_cfg0_wr ##1 (s_mask0_rd and !reg_wr) |=> reg_rdata[5:0] == $past(reg_wdata[5:0], 2);
  endproperty
  a_cfg_readback: assert property (p_cfg_readback) else $error("mask readback wrong");

  property p_lvl_refuse;
    @(posedge ref_clk) disable iff (rst)
      reg_wr && reg_addr == GEN_LVL_OFS && reg_wdata > 32'h7 |=> st_q.lvl_q[0] == $past(st_q.lvl_q[0]);
  endproperty
  a_lvl_refuse: assert property (p_lvl_refuse) else $error("illegal level taken");

  property p_gen_sel;
    @(posedge ref_clk) disable iff (rst)
      reg_wr && reg_addr == (GEN_LVL_OFS | GEN_STRIDE) |=> st_q.lvl_q[0] == $past(st_q.lvl_q[0]);
  endproperty
  a_gen_sel: assert property (p_gen_sel) else $error("generator 1 write hit 0");

  property p_dav;
    @(posedge ref_clk) disable iff (rst)
      buf_word_count != 16'h0 |=> st_q.cond_q[DATA_AVAILABLE_EVENT] ##1 1'b1;
  endproperty
  a_dav: assert property (p_dav) else $error("data available missing");

  property p_blk;
    @(posedge ref_clk) disable iff (rst)
      buf_word_count < st_q.blk_size_q |=> !st_q.cond_q[BLOCK_AVAILABLE_EVENT];
  endproperty
  a_blk: assert property (p_blk) else $error("block available too early");

  property p_armed;
    @(posedge ref_clk) disable iff (rst)
      meas_armed ##1 meas_stopped |-> st_q.cond_q[ARMED_WAITING_EVENT] ##1 st_q.cond_q[ACQUISITION_STOPPED_EVENT];
  endproperty
  a_armed: assert property (p_armed) else $error("armed or stopped lost");

  property p_rd_idle;
    @(posedge ref_clk) disable iff (rst)
      !rst && !reg_rd |=> reg_rdata == 32'h0000_0000;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");

  property p_stopped;
    @(posedge ref_clk) disable iff (rst)
      !rst && meas_stopped |=> st_q.cond_q[ACQUISITION_STOPPED_EVENT];
  endproperty
  a_stopped: assert property (p_stopped) else $error("stopped condition lost");

  // two synchroniser stages plus the condition register
  property p_over_range;
    @(posedge ref_clk) disable iff (rst)
      !rst && over_range_in |-> ##3 st_q.cond_q[INPUT_OVER_RANGE_EVENT];
  endproperty
  a_over_range: assert property (p_over_range) else $error("over range condition lost");

  property p_fault;
    @(posedge ref_clk) disable iff (rst)
      !rst && conv_fault_in |-> ##3 st_q.cond_q[CONVERTER_FAULT_EVENT];
  endproperty
  a_fault: assert property (p_fault) else $error("converter fault condition lost");

  property p_mask_quiet;
    @(posedge ref_clk) disable iff (rst)
      !any_hit[0] && st_q.lvl_q[1] == 3'h0 |=> bus_irq_oe == 7'h00;
  endproperty
  a_mask_quiet: assert property (p_mask_quiet) else $error("masked condition drove a line");

endmodule : dbig_top

`default_nettype wire

// ---- tb/dbig_bus_model.sv ----
// dbig_bus_model: the seven open-drain bus request lines with their pull-ups,
// plus other modules on the bus that may pull lines of their own.
// assumes device oe high means the device drives its out value onto the line.
`timescale 1ns/1ps
`default_nettype none

module dbig_bus_model
  import dbig_pkg::*;
(
  // device side
  input  wire logic [dbig_pkg::LINE_W-1:0] dev_oe,
  input  wire logic [dbig_pkg::LINE_W-1:0] dev_out,
  // other requesters on the bus
  input  wire logic [dbig_pkg::LINE_W-1:0] other_pull,
  // resolved line levels
  output logic      [dbig_pkg::LINE_W-1:0] line_lvl
);
  // a released line floats back high through its pull-up
  assign line_lvl = ~((dev_oe & ~dev_out) | other_pull);
endmodule : dbig_bus_model

`default_nettype wire

// ---- tb/tb.sv ----
// tb: register-level tests of the dual bus interrupt generator.
// assumes the bench is the only register master and drives every status input.
`timescale 1ns/1ps
`default_nettype none

module tb;
  import dbig_pkg::*;

  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic        ref_clk = 1'b0;
  logic        rst     = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [15:0] buf_word_count = 16'h0;
  logic        meas_armed = 1'b0;
  logic        meas_stopped = 1'b0;
  logic        over_range_in = 1'b0;
  logic        conv_fault_in = 1'b0;
  logic [6:0]  bus_irq_in;
  logic [6:0]  bus_irq_out;
  logic [6:0]  bus_irq_oe;
  logic        irq;
  logic [6:0]  other_pull = 7'h00;
  int          mismatches = 0;
  int          n_tests = 0;
  int          cyc = 0;

  always #5 ref_clk = ~ref_clk;

  dbig_top dut (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
                .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
                .buf_word_count(buf_word_count), .meas_armed(meas_armed),
                .meas_stopped(meas_stopped), .over_range_in(over_range_in),
                .conv_fault_in(conv_fault_in), .bus_irq_in(bus_irq_in),
                .bus_irq_out(bus_irq_out), .bus_irq_oe(bus_irq_oe), .irq(irq));

  dbig_bus_model bus (.dev_oe(bus_irq_oe), .dev_out(bus_irq_out), .other_pull(other_pull),
                      .line_lvl(bus_irq_in));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic test_done();
    $display("checks %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : test_done

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic cycles(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : cycles

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
  endtask : wr

  // write then read with no idle cycle between the two strobes
  task automatic wr_rd(input logic [7:0] wa, input logic [31:0] d, input logic [7:0] ra,
                       input logic [31:0] exp);
    @(posedge ref_clk);
    reg_addr  <= wa;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge ref_clk);
    reg_wr    <= 1'b0;
    reg_addr  <= ra;
    reg_rd    <= 1'b1;
    @(posedge ref_clk);
    reg_rd    <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask : wr_rd

  // read data stand only in the cycle after the strobe
  task automatic chk_rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge ref_clk);
    reg_rd   <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask : chk_rd

  // c selects one condition (c 1 also raises data available), -1 none; assumes block size of 2 words
  task automatic set_cond(input int c);
    @(posedge ref_clk);
    buf_word_count <= (c == 0) ? 16'h0001 : (c == 1) ? 16'h0002 : 16'h0000;
    meas_armed     <= (c == 2);
    meas_stopped   <= (c == 3);
    over_range_in  <= (c == 4);
    conv_fault_in  <= (c == 5);
  endtask : set_cond

  function automatic logic [31:0] line_of(input int l);
    return (l == 0) ? 32'h0 : (32'h1 << (l - 1));
  endfunction : line_of

  // ----------------------------------------------------------------
  // timeout
  // ----------------------------------------------------------------
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 30000) begin
      mismatches++;
      test_done();
    end
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    cycles(10);
    rst <= 1'b0;
    chk_rd(GEN_CFG_OFS, 32'h0);
    chk_rd(GEN_CFG_OFS | GEN_STRIDE, 32'h0);
    chk_rd(BLK_SIZE_OFS, 32'h400);
    chk(32'(bus_irq_oe), 32'h0);
    wr(BLK_SIZE_OFS, 32'h2);
    chk_rd(BLK_SIZE_OFS, 32'h2);
    wr_rd(GEN_CFG_OFS, 32'h0305, GEN_MASK_OFS, 32'h5);
    chk_rd(GEN_LVL_OFS, 32'h3);
    wr(GEN_MASK_OFS | GEN_STRIDE, 32'h2a);
    wr(GEN_LVL_OFS | GEN_STRIDE, 32'h6);
    chk_rd(GEN_CFG_OFS | GEN_STRIDE, 32'h062a);
    wr(GEN_LVL_OFS, 32'h8);
    chk_rd(GEN_LVL_OFS, 32'h3);
    wr(GEN_MASK_OFS, 32'h40);
    chk_rd(GEN_MASK_OFS, 32'h5);
    chk_rd(8'h3c, 32'h0);
    // every level of generator 0 and levels 1 to 7 of generator 1 against every condition
    for (int l = 0; l < 8; l++) begin
      for (int c = 0; c < 6; c++) begin
        // generator 1 only through select bit
        wr(GEN_CFG_OFS, (32'(l) << 8) | (32'h1 << c));
        wr(GEN_CFG_OFS | GEN_STRIDE, (32'((l % 7) + 1) << 8) | (32'h1 << c));
        set_cond(c);
        cycles(6);
        chk_rd(COND_OFS, (c == 1) ? 32'h3 : (32'h1 << c));
        chk(32'(bus_irq_oe), line_of(l) | line_of((l % 7) + 1));
        chk(32'(bus_irq_out), 32'h0);
        chk(32'(irq), 32'h0);
        set_cond(-1);
        cycles(6);
        chk(32'(bus_irq_oe), 32'h0);
      end
    end
    // a mask without the active bit stays quiet
    wr(GEN_MASK_OFS, 32'h3e);
    wr(GEN_LVL_OFS, 32'h7);
    wr(GEN_LVL_OFS | GEN_STRIDE, 32'h0);
    set_cond(0);
    cycles(6);
    chk(32'(bus_irq_oe), 32'h0);
    set_cond(1);
    cycles(6);
    chk(32'(bus_irq_oe), 32'h40);
    wr(GEN_LVL_OFS, 32'h0);
    cycles(3);
    chk(32'(bus_irq_oe), 32'h0);
    // local interrupt: sticky status, mask, write-one clear
    set_cond(-1);
    cycles(6);
    wr(IRQ_STAT_OFS, 32'h3f);
    chk_rd(IRQ_STAT_OFS, 32'h0);
    wr(IRQ_MASK_OFS, 32'h04);
    set_cond(2);
    cycles(6);
    chk(32'(irq), 32'h1);
    set_cond(-1);
    cycles(4);
    chk(32'(irq), 32'h1);
    chk_rd(IRQ_STAT_OFS, 32'h04);
    wr(IRQ_STAT_OFS, 32'h04);
    cycles(3);
    chk(32'(irq), 32'h0);
    set_cond(3);
    cycles(6);
    chk(32'(irq), 32'h0);
    chk_rd(IRQ_STAT_OFS, 32'h08);
    chk_rd(IRQ_MASK_OFS, 32'h04);
    // armed then stopped back to back
    set_cond(2);
    set_cond(3);
    cycles(2);
    chk_rd(COND_OFS, 32'h08);
    // sensed bus lines with another requester on line 3
    @(posedge ref_clk);
    other_pull <= 7'h04;
    cycles(5);
    chk_rd(LINES_OFS, 32'h7b);
    test_done();
  end
endmodule : tb

`default_nettype wire
